//--- core/crd_pkg.sv
/*
 * Shared constants and carrier types for the control-register, coprocessor
 * dispatch, miscellaneous and load decode block.
 * Assumes a single 250 MHz clock domain and 32-bit instruction words.
 */
package crd_pkg;

	// Instruction format selector values, bits 31:30
	localparam logic [1:0] FMT_BRANCH = 2'h0;
	localparam logic [1:0] FMT_ALU = 2'h2;
	localparam logic [1:0] FMT_MEM = 2'h3;
	localparam logic [2:0] OP2_RESERVED_TRAP = 3'h0;

	// Function codes for control register access and operate groups
	localparam logic [5:0] FN_READ_MUL_STEP = 6'h28;
	localparam logic [5:0] FN_READ_PROCESSOR_STATE = 6'h29;
	localparam logic [5:0] FN_READ_WINDOW_INVALID_MASK = 6'h2a;
	localparam logic [5:0] FN_READ_TRAP_BASE = 6'h2b;
	localparam logic [5:0] FN_WRITE_MUL_STEP = 6'h30;
	localparam logic [5:0] FN_WRITE_PROCESSOR_STATE = 6'h31;
	localparam logic [5:0] FN_WRITE_WINDOW_INVALID_MASK = 6'h32;
	localparam logic [5:0] FN_WRITE_TRAP_BASE = 6'h33;
	localparam logic [5:0] FN_FLOAT_OPERATE_A = 6'h34;
	localparam logic [5:0] FN_FLOAT_OPERATE_B = 6'h35;
	localparam logic [5:0] FN_COPROC_OPERATE_A = 6'h36;
	localparam logic [5:0] FN_COPROC_OPERATE_B = 6'h37;
	localparam logic [5:0] FN_ICACHE_WORD_FLUSH = 6'h3b;

	// Load function codes
	localparam logic [5:0] FN_WORD_LOAD = 6'h00;
	localparam logic [5:0] FN_DOUBLE_LOAD = 6'h03;
	localparam logic [5:0] FN_ALTERNATE_WORD_LOAD = 6'h10;
	localparam logic [5:0] FN_ALTERNATE_DOUBLE_LOAD = 6'h13;
	localparam logic [5:0] FN_FLOAT_WORD_LOAD = 6'h20;
	localparam logic [5:0] FN_FLOAT_STATUS_LOAD = 6'h21;
	localparam logic [5:0] FN_FLOAT_DOUBLE_LOAD = 6'h23;
	localparam logic [5:0] FN_COPROC_WORD_LOAD = 6'h30;
	localparam logic [5:0] FN_COPROC_STATUS_LOAD = 6'h31;
	localparam logic [5:0] FN_COPROC_DOUBLE_LOAD = 6'h33;

	// Processor state register fields and reset values
	localparam int PSR_SUPERVISOR_BIT = 7;
	localparam int PSR_FPU_ENABLE_BIT = 12;
	localparam logic [31:0] PSR_RESET = 32'h0000_0080;
	localparam logic [31:0] WIM_RESET = 32'h0000_0000;
	localparam logic [31:0] TBR_RESET = 32'h0000_0000;
	localparam logic [31:0] MUL_STEP_RESET = 32'h0000_0000;

	// Register bus map, byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PROCESSOR_STATE = 8'h08;
	localparam logic [7:0] ADDR_WINDOW_INVALID_MASK = 8'h0c;
	localparam logic [7:0] ADDR_TRAP_BASE = 8'h10;
	localparam logic [7:0] ADDR_MUL_STEP = 8'h14;
	localparam logic [7:0] ADDR_TRAP_COUNT = 8'h18;
	localparam int CTRL_EXT_ICACHE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pin levels assumed while the synchronisers are still filling
	localparam logic [2:0] PIN_RESET = 3'h4;

	typedef enum logic [1:0] {
		TRAP_NONE,
		TRAP_PRIVILEGED,
		TRAP_FP_DISABLED,
		TRAP_ILLEGAL
	} crd_trap_type;

	typedef enum logic [1:0] {
		CREG_MUL_STEP,
		CREG_PROCESSOR_STATE,
		CREG_WINDOW_INVALID_MASK,
		CREG_TRAP_BASE
	} crd_creg_type;

	typedef enum logic [3:0] {
		LC_NONE,
		LC_WORD,
		LC_DOUBLE,
		LC_ALT_WORD,
		LC_ALT_DOUBLE,
		LC_FLOAT_WORD,
		LC_FLOAT_STATUS,
		LC_FLOAT_DOUBLE,
		LC_COPROC_WORD,
		LC_COPROC_STATUS,
		LC_COPROC_DOUBLE
	} crd_load_type;

	typedef struct packed {
		logic is_mem;
		logic [4:0] dest;
		logic [5:0] func;
		logic [4:0] src1;
		logic imm_sel;
		logic [4:0] src2;
		logic [31:0] imm;
		logic [7:0] asi;
		crd_load_type lclass;
		logic bad_form;
	} crd_mem_dec_type;

	typedef struct packed {
		logic valid;
		logic [31:0] word;
		logic [31:0] operand;
	} crd_issue_type;

	typedef struct packed {
		logic done;
		logic wr_dest;
		logic [31:0] value;
		crd_load_type lclass;
		logic [4:0] dest;
	} crd_result_type;

	typedef struct packed {
		logic taken;
		crd_trap_type cause;
	} crd_trap_out_type;

	typedef struct packed {
		logic launch;
		logic [31:0] word;
	} crd_copr_type;

endpackage : crd_pkg

//--- core/crd_mem_decode.sv
/*
 * Field decoder for the memory instruction format.
 * Purely combinational; the caller registers whatever it keeps.
 */
`timescale 1ns/1ns
`default_nettype none

module crd_mem_decode
	import crd_pkg::*;
(
	input wire logic [31:0] word,
	output crd_pkg::crd_mem_dec_type dec
);

	// Field extraction and load classification
	always_comb
	begin
		dec = '0;
		dec.is_mem = (word[31:30] == FMT_MEM);
		dec.dest = word[29:25];
		dec.func = word[24:19];
		dec.src1 = word[18:14];
		dec.imm_sel = word[13];
		// Register form ignores bits 12:5 except as space id
		dec.src2 = word[13] ? 5'h00 : word[4:0];
		dec.imm = word[13] ? {{19{word[12]}}, word[12:0]} : 32'h0000_0000;
		dec.asi = word[12:5];
		dec.lclass = LC_NONE;
		if (dec.is_mem)
		begin
			case (word[24:19])
				FN_WORD_LOAD: dec.lclass = LC_WORD;
				FN_DOUBLE_LOAD: dec.lclass = LC_DOUBLE;
				FN_ALTERNATE_WORD_LOAD: dec.lclass = LC_ALT_WORD;
				FN_ALTERNATE_DOUBLE_LOAD: dec.lclass = LC_ALT_DOUBLE;
				FN_FLOAT_WORD_LOAD: dec.lclass = LC_FLOAT_WORD;
				FN_FLOAT_STATUS_LOAD: dec.lclass = LC_FLOAT_STATUS;
				FN_FLOAT_DOUBLE_LOAD: dec.lclass = LC_FLOAT_DOUBLE;
				FN_COPROC_WORD_LOAD: dec.lclass = LC_COPROC_WORD;
				FN_COPROC_STATUS_LOAD: dec.lclass = LC_COPROC_STATUS;
				FN_COPROC_DOUBLE_LOAD: dec.lclass = LC_COPROC_DOUBLE;
				default: dec.lclass = LC_NONE;
			endcase
		end
		// Alternate space loads have no immediate form
		dec.bad_form = word[13] && (dec.lclass == LC_ALT_WORD || dec.lclass == LC_ALT_DOUBLE);
	end

endmodule : crd_mem_decode

`default_nettype wire

//--- core/crd_ctl_regs.sv
/*
 * The four privileged or special control registers.
 * Assumes the caller has already applied the supervisor check.
 */
`timescale 1ns/1ns
`default_nettype none

module crd_ctl_regs
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire crd_pkg::crd_creg_type wr_sel,
	input wire logic [31:0] wr_data,
	output logic [31:0] mul_step_ff,
	output logic [31:0] psr_ff,
	output logic [31:0] wim_ff,
	output logic [31:0] tbr_ff
);

	// Each write lands on the edge that ends its issue cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mul_step_ff <= MUL_STEP_RESET;
			psr_ff <= PSR_RESET;
			wim_ff <= WIM_RESET;
			tbr_ff <= TBR_RESET;
		end
		else if (wr_en)
		begin
			unique case (wr_sel)
				CREG_MUL_STEP: mul_step_ff <= wr_data;
				CREG_PROCESSOR_STATE: psr_ff <= wr_data;
				CREG_WINDOW_INVALID_MASK: wim_ff <= wr_data;
				CREG_TRAP_BASE: tbr_ff <= wr_data;
			endcase
		end
	end

endmodule : crd_ctl_regs

`default_nettype wire

//--- core/crd_decode_top.sv
/*
 * Decode and dispatch for control register access, float and coprocessor
 * operate launch, the reserved trap and flush instructions, and loads.
 * Assumes an upstream stage presents one instruction per cycle with its
 * computed operand, and an AXI4-Lite master for the status registers.
 */
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Control register reads and writes each complete in one cycle.
// - Opcode alone selects which control register is read or written.
// - State, window mask and trap base access only in supervisor mode.
// - Float operate takes one launch cycle; result never overwrites sources.
// - Float instruction traps as disabled without unit or enable bit.
// - Coprocessor operate launches in one cycle; traps disabled when absent.
// - Only format and function code decoded here; rest goes to unit.
// - Float unit runs concurrently with integer instructions, may overlap.
// - Reserved trap instruction takes one cycle and raises illegal trap.
// - Icache word flush completes in one cycle as a no-operation.
// - With external cache and flush trap pin low, flush raises illegal.
// - Memory format fields sit at 31:30, 29:25, 24:19, 18:14, 13, 12:0.
// - Register form uses bits 4:0; immediate form uses signed low bits.
// - Codes 000000 and 000011 decode as word and double load.
// - Codes 110000, 110001, 110011 decode as coprocessor loads.
// - Codes 100000, 100001, 100011 decode as float loads.
// - Float and coprocessor loads take the load path, not operate dispatch.
module crd_decode_top
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire crd_pkg::crd_issue_type issue,
	output crd_pkg::crd_result_type result,
	output crd_pkg::crd_trap_out_type trap,
	output crd_pkg::crd_copr_type fpu_dispatch,
	output crd_pkg::crd_copr_type coproc_dispatch,
	output crd_pkg::crd_mem_dec_type mem_op,
	input wire logic fpu_present_pin,
	input wire logic coproc_present_pin,
	input wire logic flush_trap_pin,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic [2:0] pin_in;
	logic [2:0] pin_s1_ff;
	logic [2:0] pin_s2_ff;
	logic [2:0] pin_s3_ff;
	logic [2:0] pin_ff;
	logic fpu_ok;
	logic coproc_ok;
	logic flush_trap_level;
	logic [31:0] mul_step_ff;
	logic [31:0] psr_ff;
	logic [31:0] wim_ff;
	logic [31:0] tbr_ff;
	logic [31:0] ctrl_ff;
	logic [31:0] trap_count_ff;
	crd_trap_type last_cause_ff;
	crd_mem_dec_type dec;
	logic [1:0] fmt;
	logic [5:0] func;
	logic supervisor;
	logic fpu_enabled;
	logic acc_rd;
	logic acc_wr;
	logic acc_priv;
	crd_creg_type acc_sel;
	logic is_float_operate;
	logic is_coproc_operate;
	logic is_fp_load;
	logic is_cp_load;
	logic is_reserved_trap_instruction;
	logic is_icache_word_flush;
	crd_trap_type nxt_cause;
	logic reg_wr_en;
	logic [31:0] rd_value;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// Pin inputs pass three flops into a fourth; a change counts once stages two and three agree
	assign pin_in = {flush_trap_pin, coproc_present_pin, fpu_present_pin};
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_pin_sync
			always_ff @(posedge clk)
			begin
				if (!resetn)
				begin
					pin_s1_ff[i] <= PIN_RESET[i];
					pin_s2_ff[i] <= PIN_RESET[i];
					pin_s3_ff[i] <= PIN_RESET[i];
					pin_ff[i] <= PIN_RESET[i];
				end
				else
				begin
					pin_s1_ff[i] <= pin_in[i];
					pin_s2_ff[i] <= pin_s1_ff[i];
					pin_s3_ff[i] <= pin_s2_ff[i];
					if (pin_s2_ff[i] == pin_s3_ff[i])
						pin_ff[i] <= pin_s3_ff[i];
				end
			end
		end
	endgenerate
	assign fpu_ok = pin_ff[0];
	assign coproc_ok = pin_ff[1];
	assign flush_trap_level = pin_ff[2];

	// Memory format fields
	crd_mem_decode u_mem_decode (
		.word(issue.word),
		.dec(dec)
	);

	// Only the format selector and function code are looked at here
	assign fmt = issue.word[31:30];
	assign func = issue.word[24:19];
	assign supervisor = psr_ff[PSR_SUPERVISOR_BIT];
	assign fpu_enabled = psr_ff[PSR_FPU_ENABLE_BIT];

	// Opcode classification; the function code alone picks the register
	always_comb
	begin
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		acc_sel = CREG_MUL_STEP;
		is_float_operate = 1'b0;
		is_coproc_operate = 1'b0;
		is_icache_word_flush = 1'b0;
		if (fmt == FMT_ALU)
		begin
			case (func)
				FN_READ_MUL_STEP: acc_rd = 1'b1;
				FN_READ_PROCESSOR_STATE:
				begin
					acc_rd = 1'b1;
					acc_sel = CREG_PROCESSOR_STATE;
				end
				FN_READ_WINDOW_INVALID_MASK:
				begin
					acc_rd = 1'b1;
					acc_sel = CREG_WINDOW_INVALID_MASK;
				end
				FN_READ_TRAP_BASE:
				begin
					acc_rd = 1'b1;
					acc_sel = CREG_TRAP_BASE;
				end
				FN_WRITE_MUL_STEP: acc_wr = 1'b1;
				FN_WRITE_PROCESSOR_STATE:
				begin
					acc_wr = 1'b1;
					acc_sel = CREG_PROCESSOR_STATE;
				end
				FN_WRITE_WINDOW_INVALID_MASK:
				begin
					acc_wr = 1'b1;
					acc_sel = CREG_WINDOW_INVALID_MASK;
				end
				FN_WRITE_TRAP_BASE:
				begin
					acc_wr = 1'b1;
					acc_sel = CREG_TRAP_BASE;
				end
				FN_FLOAT_OPERATE_A, FN_FLOAT_OPERATE_B: is_float_operate = 1'b1;
				FN_COPROC_OPERATE_A, FN_COPROC_OPERATE_B: is_coproc_operate = 1'b1;
				FN_ICACHE_WORD_FLUSH: is_icache_word_flush = 1'b1;
				default: acc_rd = 1'b0;
			endcase
		end
	end

	// Float and coprocessor loads are recognised but stay on the load path
	assign is_fp_load = dec.lclass inside {LC_FLOAT_WORD, LC_FLOAT_STATUS, LC_FLOAT_DOUBLE};
	assign is_cp_load = dec.lclass inside {LC_COPROC_WORD, LC_COPROC_STATUS, LC_COPROC_DOUBLE};
	assign is_reserved_trap_instruction = (fmt == FMT_BRANCH) && (issue.word[24:22] == OP2_RESERVED_TRAP);
	assign acc_priv = (acc_rd || acc_wr) && (acc_sel != CREG_MUL_STEP);

	// Trap selection; at most one class can match a given word
	always_comb
	begin
		nxt_cause = TRAP_NONE;
		if (issue.valid)
		begin
			if (acc_priv && !supervisor)
				nxt_cause = TRAP_PRIVILEGED;
			else if ((is_float_operate || is_fp_load) && !(fpu_ok && fpu_enabled))
				nxt_cause = TRAP_FP_DISABLED;
			else if ((is_coproc_operate || is_cp_load) && !coproc_ok)
				nxt_cause = TRAP_FP_DISABLED;
			else if (is_reserved_trap_instruction)
				nxt_cause = TRAP_ILLEGAL;
			else if (is_icache_word_flush && ctrl_ff[CTRL_EXT_ICACHE_BIT] && !flush_trap_level)
				nxt_cause = TRAP_ILLEGAL;
			else if (dec.bad_form)
				nxt_cause = TRAP_ILLEGAL;
		end
	end

	// A trapped write never reaches the register
	assign reg_wr_en = issue.valid && acc_wr && (nxt_cause == TRAP_NONE);

	crd_ctl_regs u_ctl_regs (
		.clk(clk),
		.resetn(resetn),
		.wr_en(reg_wr_en),
		.wr_sel(acc_sel),
		.wr_data(issue.operand),
		.mul_step_ff(mul_step_ff),
		.psr_ff(psr_ff),
		.wim_ff(wim_ff),
		.tbr_ff(tbr_ff)
	);

	// Read source chosen by opcode
	always_comb
	begin
		unique case (acc_sel)
			CREG_MUL_STEP: rd_value = mul_step_ff;
			CREG_PROCESSOR_STATE: rd_value = psr_ff;
			CREG_WINDOW_INVALID_MASK: rd_value = wim_ff;
			CREG_TRAP_BASE: rd_value = tbr_ff;
		endcase
	end

	// Every instruction retires here one cycle after issue
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			result <= '0;
			trap <= '{taken: 1'b0, cause: TRAP_NONE};
			mem_op <= '0;
		end
		else
		begin
			result.done <= issue.valid;
			result.wr_dest <= issue.valid && acc_rd && (nxt_cause == TRAP_NONE);
			result.value <= rd_value;
			result.lclass <= (nxt_cause == TRAP_NONE) ? dec.lclass : LC_NONE;
			result.dest <= dec.dest;
			trap.taken <= (nxt_cause != TRAP_NONE);
			trap.cause <= nxt_cause;
			mem_op <= dec;
		end
	end

	// Operate launch: one cycle here, then the unit runs on its own
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			fpu_dispatch <= '0;
			coproc_dispatch <= '0;
		end
		else
		begin
			fpu_dispatch.launch <= issue.valid && is_float_operate && (nxt_cause == TRAP_NONE);
			fpu_dispatch.word <= issue.word;
			coproc_dispatch.launch <= issue.valid && is_coproc_operate && (nxt_cause == TRAP_NONE);
			coproc_dispatch.word <= issue.word;
		end
	end

	// Trap statistics for software
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			trap_count_ff <= 32'h0000_0000;
			last_cause_ff <= TRAP_NONE;
		end
		else if (nxt_cause != TRAP_NONE)
		begin
			trap_count_ff <= trap_count_ff + 32'h0000_0001;
			last_cause_ff <= nxt_cause;
		end
	end

	// Bus write: address and data caught independently, answered once both held
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			ctrl_ff <= CTRL_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (aw_held_ff && w_held_ff)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= (aw_addr_ff > ADDR_TRAP_COUNT || aw_addr_ff[1:0] != 2'h0)
					? RESP_SLVERR : RESP_OKAY;
				// Only the low byte of the control word is writable; the upper bits stay at their reset value of zero
				if (aw_addr_ff == ADDR_CTRL && w_strb_ff[0])
					ctrl_ff[7:0] <= w_data_ff[7:0];
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Bus read: one outstanding read, data registered
	assign s_axi_arready = !rvalid_ff;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: rdata_ff <= ctrl_ff;
				ADDR_STATUS: rdata_ff <= {25'h0, flush_trap_level, coproc_ok, fpu_ok,
					supervisor, 1'b0, last_cause_ff};
				ADDR_PROCESSOR_STATE: rdata_ff <= psr_ff;
				ADDR_WINDOW_INVALID_MASK: rdata_ff <= wim_ff;
				ADDR_TRAP_BASE: rdata_ff <= tbr_ff;
				ADDR_MUL_STEP: rdata_ff <= mul_step_ff;
				ADDR_TRAP_COUNT: rdata_ff <= trap_count_ff;
				default:
				begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule : crd_decode_top

`default_nettype wire

//--- verification/crd_unit_model.sv
/* Behavioural float unit and coprocessor at the far side.
   Assumes the bench commands presence; launches arrive as pulses. */
`timescale 1ns/1ns
`default_nettype none
module crd_unit_model
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire crd_pkg::crd_copr_type fpu_dispatch,
	input wire crd_pkg::crd_copr_type coproc_dispatch,
	input wire logic fpu_on,
	input wire logic coproc_on,
	output logic fpu_present_pin,
	output logic coproc_present_pin
);
	logic [31:0] fq[$];
	logic [31:0] cq[$];
	int age;
	// Presence pins are plain levels; absent means low
	assign fpu_present_pin = fpu_on;
	assign coproc_present_pin = coproc_on;
	// Work queues up and retires slowly, overlapping the integer unit
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			fq.delete();
			cq.delete();
			age = 0;
		end
		else
		begin
			if (fpu_dispatch.launch === 1'b1)
				fq.push_back(fpu_dispatch.word);
			if (coproc_dispatch.launch === 1'b1)
				cq.push_back(coproc_dispatch.word);
			age = (fq.size() + cq.size() == 0) ? 0 : age + 1;
			// Oldest entry stays at the front until it retires
			if (age == 6)
			begin
				fq = (fq.size() != 0) ? fq[1:$] : fq;
				cq = (cq.size() != 0) ? cq[1:$] : cq;
				age = 0;
			end
		end
	end
endmodule : crd_unit_model
`default_nettype wire

//--- verification/crd_decode_assertions.sv
/* Port checker for the decode block.
   Assumes one clock and synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module crd_decode_assertions
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire crd_pkg::crd_issue_type issue,
	input wire crd_pkg::crd_result_type result,
	input wire crd_pkg::crd_trap_out_type trap,
	input wire crd_pkg::crd_copr_type fpu_dispatch,
	input wire crd_pkg::crd_copr_type coproc_dispatch,
	input wire crd_pkg::crd_mem_dec_type mem_op
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [31:0] w;
	logic mem, fop, cop, rsv;
	// Instruction class of the word on the issue port
	assign w = issue.word;
	assign mem = issue.valid && w[31:30] == FMT_MEM;
	assign fop = issue.valid && w[31:30] == FMT_ALU && w[24:20] == 5'h1a;
	assign cop = issue.valid && w[31:30] == FMT_ALU && w[24:20] == 5'h1b;
	assign rsv = issue.valid && w[31:30] == FMT_BRANCH && w[24:22] == OP2_RESERVED_TRAP;
	AST_ONE_CYCLE: assert property (issue.valid |=> result.done)
		else $error("no done");
	AST_NO_SPURIOUS: assert property (!issue.valid |=> !result.done)
		else $error("stray done");
	AST_RESERVED: assert property (rsv |=> trap.taken && trap.cause == TRAP_ILLEGAL)
		else $error("reserved not trapped");
	AST_FLOAT_OP: assert property (fop |=> fpu_dispatch.launch != trap.taken
		&& (fpu_dispatch.launch || trap.cause == TRAP_FP_DISABLED)) else $error("float op");
	AST_COPROC_OP: assert property (cop |=> coproc_dispatch.launch != trap.taken
		&& (coproc_dispatch.launch || trap.cause == TRAP_FP_DISABLED)) else $error("coproc op");
	AST_WHOLE_WORD: assert property (fpu_dispatch.launch |-> fpu_dispatch.word == $past(w))
		else $error("dispatch word");
	AST_FIELDS: assert property (mem |=> {mem_op.dest, mem_op.func, mem_op.src1}
		== $past(w[29:14])) else $error("mem fields");
	AST_OPERAND: assert property (mem |=> mem_op.imm_sel ?
		mem_op.imm == {{19{$past(w[12])}}, $past(w[12:0])} : mem_op.src2 == $past(w[4:0]))
		else $error("operand form");
	AST_SPACE_ID: assert property (mem && w[24:22] == 3'h2 && !w[13] |=>
		mem_op.asi == $past(w[12:5])) else $error("space id");
	AST_LOAD_PATH: assert property (mem |=> !fpu_dispatch.launch && !coproc_dispatch.launch)
		else $error("load dispatched");
	AST_COPROC_WORD: assert property (coproc_dispatch.launch |->
		coproc_dispatch.word == $past(w)) else $error("coproc word");
	cover property (fop ##1 fpu_dispatch.launch);
	cover property (trap.taken && trap.cause == TRAP_PRIVILEGED);
	cover property (trap.taken && trap.cause == TRAP_ILLEGAL);
endmodule : crd_decode_assertions
bind crd_decode_top crd_decode_assertions chk (.clk(clk), .resetn(resetn), .issue(issue),
	.result(result), .trap(trap), .fpu_dispatch(fpu_dispatch),
	.coproc_dispatch(coproc_dispatch), .mem_op(mem_op));
`default_nettype wire

//--- verification/tb.sv
/* Bench: reference model of the decode block with the unit partner.
   Assumes the package map and one-cycle answers of the hand-over. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb;
	import crd_pkg::*;
	logic clk = 0, resetn = 0, fpu_on = 0, coproc_on = 0, flush_trap_pin = 1, ext = 0;
	logic fpu_present_pin, coproc_present_pin, awr, wr_r, bv, arr, rv;
	logic [7:0] aa = 0, ra = 0;
	logic [31:0] wd = 0, rd, seed = 32'h0000_19cc;
	logic aw = 0, wv = 0, br = 0, ar = 0, rr = 0;
	logic [1:0] bresp, rresp;
	crd_issue_type issue = '0;
	crd_result_type result;
	crd_trap_out_type trap;
	crd_copr_type fpu_dispatch, coproc_dispatch;
	logic [31:0] m_reg [4];
	logic [46:0] exq[$];
	logic [31:0] n_trap;
	logic [1:0] last_c;
	logic [46:0] got, want;
	logic [5:0] alu_fn [12] = '{6'h28, 6'h29, 6'h2a, 6'h2b, 6'h30, 6'h32, 6'h33, 6'h34, 6'h35,
		6'h36, 6'h37, 6'h3b};
	logic [5:0] float_word_load [10] = '{6'h00, 6'h03, 6'h10, 6'h13, 6'h20, 6'h21, 6'h23, 6'h30, 6'h31, 6'h33};
	int n_fail = 0, checked = 0;
	crd_decode_top uut (.clk, .resetn, .issue, .result, .trap, .fpu_dispatch, .coproc_dispatch,
		.mem_op(), .fpu_present_pin, .coproc_present_pin, .flush_trap_pin, .s_axi_awaddr(aa),
		.s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(ar), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
	crd_unit_model partner (.clk, .resetn, .fpu_dispatch, .coproc_dispatch, .fpu_on, .coproc_on,
		.fpu_present_pin, .coproc_present_pin);
	initial forever #2 clk = ~clk;
	// Watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Dest only matters for loads, read value only for a good read
	function logic [46:0] pk(logic tk, logic [1:0] c, logic wr, logic [31:0] v,
		logic [3:0] lc, logic fl, logic cl, logic [4:0] d);
		return {tk, c, wr, wr ? v : 32'h0, lc, fl, cl, lc != 4'h0 ? d : 5'h0};
	endfunction : pk
	// Each finished instruction is matched with the oldest prediction
	always @(posedge clk)
		if (resetn === 1'b1 && result.done === 1'b1)
		begin
			got = pk(trap.taken, trap.cause, result.wr_dest, result.value, result.lclass,
				fpu_dispatch.launch, coproc_dispatch.launch, result.dest);
			want = exq.size() ? exq.pop_front() : 47'h0;
			`CHK(got, want)
		end
	task send(input logic [31:0] w, input logic [31:0] op);
		logic [5:0] f;
		logic [1:0] c;
		logic wr, fl, cl, fok;
		logic [31:0] v;
		logic [3:0] lc;
		int i;
		f = w[24:19];
		fok = fpu_on && m_reg[1][PSR_FPU_ENABLE_BIT];
		{c, wr, fl, cl, v, lc} = '0;
		if (w[31:30] == FMT_ALU && (f[5:2] == 4'ha || f[5:2] == 4'hc))
		begin
			if (f[1:0] != 2'h0 && !m_reg[1][PSR_SUPERVISOR_BIT])
				c = TRAP_PRIVILEGED;
			else if (f[3])
				{wr, v} = {1'b1, m_reg[f[1:0]]};
			else
				m_reg[f[1:0]] = op;
		end
		else if (w[31:30] == FMT_ALU && f[5:1] == 5'h1a)
			{c, fl} = fok ? 3'h1 : {TRAP_FP_DISABLED, 1'b0};
		else if (w[31:30] == FMT_ALU && f[5:1] == 5'h1b)
			{c, cl} = coproc_on ? 3'h1 : {TRAP_FP_DISABLED, 1'b0};
		else if (w[31:30] == FMT_ALU)
			c = (ext && !flush_trap_pin) ? TRAP_ILLEGAL : TRAP_NONE;
		else if (w[31:30] == FMT_BRANCH)
			c = TRAP_ILLEGAL;
		else
		begin
			for (i = 0; i < 10; i++)
				if (f == float_word_load[i])
					lc = 4'(i + 1);
			if ((f[5:4] == 2'h2 && !fok) || (f[5:4] == 2'h3 && !coproc_on))
				{c, lc} = {TRAP_FP_DISABLED, 4'h0};
			else if (f[5:4] == 2'h1 && w[13])
				{c, lc} = {TRAP_ILLEGAL, 4'h0};
		end
		exq.push_back(pk(c != TRAP_NONE, c, wr, v, lc, fl, cl, w[29:25]));
		if (c != TRAP_NONE)
			{n_trap, last_c} = {n_trap + 32'h1, c};
		issue <= '{1'b1, w, op};
		@(posedge clk);
	endtask : send
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		{aa, wd, aw, wv, br} <= {a, d, 3'h7};
		do
		begin
			@(posedge clk);
			if (awr === 1'b1) aw <= 1'b0;
			if (wr_r === 1'b1) wv <= 1'b0;
		end
		while (bv !== 1'b1);
		br <= 1'b0;
		`CHK(bresp, er)
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		{ra, ar, rr} <= {a, 2'h3};
		do
		begin
			@(posedge clk);
			if (arr === 1'b1) ar <= 1'b0;
		end
		while (rv !== 1'b1);
		rr <= 1'b0;
		`CHK({rresp, rd}, {er, ed})
	endtask : axi_rd
	task check_regs();
		axi_rd(ADDR_PROCESSOR_STATE, m_reg[1], RESP_OKAY);
		axi_rd(ADDR_WINDOW_INVALID_MASK, m_reg[2], RESP_OKAY);
		axi_rd(ADDR_TRAP_BASE, m_reg[3], RESP_OKAY);
		axi_rd(ADDR_MUL_STEP, m_reg[0], RESP_OKAY);
		axi_rd(ADDR_TRAP_COUNT, n_trap, RESP_OKAY);
		axi_rd(ADDR_STATUS, {25'h0, flush_trap_pin, coproc_on, fpu_on,
			m_reg[1][PSR_SUPERVISOR_BIT], 1'b0, last_c}, RESP_OKAY);
	endtask : check_regs
	// Every operate, load and reserved code and each control code but the state write, back to back, random fields
	task all_ops();
		logic [31:0] r;
		int i;
		for (i = 0; i < 22; i++)
		begin
			r = xs();
			if (i < 12)
				send({FMT_ALU, r[29:25], alu_fn[i], r[18:0]}, xs());
			else
				send({FMT_MEM, r[29:25], float_word_load[i - 12], r[18:0]}, r);
		end
		send({FMT_BRANCH, r[29:25], OP2_RESERVED_TRAP, r[21:0]}, r);
		issue.valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : all_ops
	task do_reset();
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		m_reg = '{MUL_STEP_RESET, PSR_RESET, WIM_RESET, TBR_RESET};
		{n_trap, last_c} = '0;
		ext = 1'b0;
		repeat (6) @(posedge clk);
	endtask : do_reset
	task wrap_up();
		`CHK(exq.size(), 0)
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Units absent, then present with float enable clear, set, then user mode
	initial
	begin
		do_reset();
		check_regs();
		axi_rd(8'h1c, 32'h0, RESP_SLVERR);
		axi_wr(8'h1c, xs(), RESP_SLVERR);
		all_ops();
		axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		ext = 1'b1;
		axi_rd(ADDR_CTRL, 32'h1, RESP_OKAY);
		{fpu_on, coproc_on, flush_trap_pin} <= 3'h6;
		repeat (6) @(posedge clk);
		all_ops();
		send({FMT_ALU, 5'h0, FN_WRITE_PROCESSOR_STATE, 19'h0}, 32'h1080);
		all_ops();
		check_regs();
		flush_trap_pin <= 1'b1;
		send({FMT_ALU, 5'h0, FN_WRITE_PROCESSOR_STATE, 19'h0}, 32'h1000);
		all_ops();
		check_regs();
		do_reset();
		check_regs();
		wrap_up();
	end
endmodule : tb
`default_nettype wire
